// ---- core/rfa_pkg.sv ----
// package of offsets, field layouts and reset values for the regulator fault aggregator
package rfa_pkg;
	localparam int          NUM_SUPPLIES = 27;
	localparam int          NUM_DETECT   = 4;
	localparam int          SYNC_WIDTH   = NUM_SUPPLIES * NUM_DETECT + 3;
	// extended register region holding the per-rail fault bits
	localparam logic [8:0]  EXT_REGION_LO = 9'h180;
	localparam logic [8:0]  EXT_REGION_HI = 9'h1FF;
	localparam logic [8:0]  ADDR_RAIL_A   = 9'h1CC;
	localparam logic [8:0]  ADDR_RAIL_B   = 9'h1CD;
	localparam logic [8:0]  ADDR_RAIL_C   = 9'h1CE;
	localparam logic [8:0]  ADDR_RAIL_D   = 9'h1CF;
	localparam logic [8:0]  ADDR_L1_FLAGS = 9'h030;
	localparam logic [8:0]  ADDR_L1_MASK  = 9'h031;
	localparam logic [7:0]  RAIL_RESET    = 8'h00;
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [2:0]  MASK_RESET    = 3'h3;
	// first supply index held by each fault register, and the used width of rail registers a and d
	localparam int          RAIL_A_BASE  = 0;
	localparam int          RAIL_A_BITS  = 7;
	localparam int          RAIL_B_BASE  = 7;
	localparam int          RAIL_C_BASE  = 15;
	localparam int          RAIL_D_BASE  = 23;
	localparam int          RAIL_D_BITS  = 4;
	// level-1 flag and mask bit positions
	localparam int          BIT_THERMAL  = 0;
	localparam int          BIT_SUMMARY  = 1;
	localparam int          BIT_REGFAIL  = 2;
	// which detectors each supply implements: [3]=short [2]=over-current [1]=over-v [0]=under-v
	localparam logic [NUM_SUPPLIES*NUM_DETECT-1:0] SUPPLY_DETECT_USED = {NUM_SUPPLIES{4'hF}};
endpackage

// ---- core/rfa_sync3.sv ----
// three-flop synchroniser that accepts a change once the second and third stage agree
`timescale 1ns/1ps
module rfa_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK,
	input  wire logic             SYS_RST,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	output logic      [WIDTH-1:0] SYNC_OUT
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, stable_q;
	logic [WIDTH-1:0] stable_d;

	// per bit, the settled value moves only when the two later stages match
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
		end
	end

	// first stage is read only by the second stage
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			stable_q <= '0;
		end else begin
			s1_q     <= ASYNC_IN;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
		end
	end

	assign SYNC_OUT = stable_q;
endmodule

// ---- core/rfa_top.sv ----
// regulator fault aggregator: per-rail fault status, summary source and level-1 interrupt
//
// Contract
// - each supply fault is the OR of the detectors that supply implements
// - all supply faults OR together into one summary fault source
// - unmasked summary sets level-1 regulator fault, which asserts the host interrupt
// - per-rail fault bits live in the extended region 0x180 to 0x1FF
// - first rail register holds seven supplies in bits 0-6, bit 7 reserved
// - second rail register holds eight further supplies in bits 0-7
// - third rail register holds eight further supplies in bits 0-7
// - fourth rail register holds four supplies in bits 0-3, bits 7-4 reserved
// - a rail bit reads 1 while its supply has a fault, else 0
// - read-only level-1 flags: thermal bit 0, summary bit 1, regulator-fail bit 2
// - read-write mask, reset 0x03, bits 0-2, one masks the matching flag
//
// Register map
//   0x030  level-1 flags, read only, bits 2:0
//   0x031  level-1 mask, bits 2:0, the only writable location
//   0x1CC  rail status a, supplies 0-6
//   0x1CD  rail status b, supplies 7-14
//   0x1CE  rail status c, supplies 15-22
//   0x1CF  rail status d, supplies 23-26
//
// Latency
//   a detector change reaches rail status five edges later and the level-1
//   fault and host pin on the sixth; pulses under two cycles may vanish
`timescale 1ns/1ps
module rfa_top
	import rfa_pkg::*;
(
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	input  wire logic [NUM_SUPPLIES-1:0] UNDER_VOLT_DET,
	input  wire logic [NUM_SUPPLIES-1:0] OVER_VOLT_DET,
	input  wire logic [NUM_SUPPLIES-1:0] OVER_CURR_DET,
	input  wire logic [NUM_SUPPLIES-1:0] SHORT_CIRC_DET,
	input  wire logic                    THERMAL_WARN_DET,
	input  wire logic                    BAT_OVERCURR_DET,
	input  wire logic                    REGULATOR_FAIL_DET,
	input  wire logic [8:0]              REG_ADDR,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	input  wire logic [7:0]              REG_WDATA,
	output logic      [7:0]              REG_RDATA,
	output logic      [NUM_SUPPLIES-1:0] SUPPLY_FAULT_SIGNAL,
	output logic                         FAULT_SUMMARY_SOURCE,
	output logic                         REGULATOR_FAULT_LEVEL1,
	output logic                         HOST_INTERRUPT_PIN
);
	logic [SYNC_WIDTH-1:0]   raw_in, sync_in;
	logic [NUM_SUPPLIES-1:0] fault_now;
	logic [NUM_SUPPLIES-1:0] rail_q, rail_d;
	logic                    summary_q, summary_d;
	logic [2:0]              flags_q, flags_d;
	logic [2:0]              mask_q, mask_d;
	logic                    l1_q, l1_d;
	logic                    irq_q, irq_d;
	logic [7:0]              rdata_q, rdata_d;
	logic [7:0]              rd_mux;
	// decoded helpers for the register port and the level-1 path
	logic [7:0]              rail_img_a, rail_img_b, rail_img_c, rail_img_d;
	logic                    in_ext_region;
	logic                    mask_wr;
	logic                    thermal_s, bat_oc_s, reg_fail_s;
	logic [2:0]              pend;

	// analogue detectors arrive unsynchronised, so every one passes the three-flop filter
	assign raw_in = {REGULATOR_FAIL_DET, BAT_OVERCURR_DET, THERMAL_WARN_DET,
		SHORT_CIRC_DET, OVER_CURR_DET, OVER_VOLT_DET, UNDER_VOLT_DET};

	rfa_sync3 #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.CLK      (CLK),
		.SYS_RST  (SYS_RST),
		.ASYNC_IN (raw_in),
		.SYNC_OUT (sync_in)
	);

	// per supply OR over the detectors that the supply actually has
	generate
		for (genvar s = 0; s < NUM_SUPPLIES; s++) begin : g_supply
			logic [NUM_DETECT-1:0] det;
			assign det = {sync_in[3*NUM_SUPPLIES+s], sync_in[2*NUM_SUPPLIES+s],
				sync_in[NUM_SUPPLIES+s], sync_in[s]};
			assign fault_now[s] = |(det & SUPPLY_DETECT_USED[s*NUM_DETECT +: NUM_DETECT]);
		end
	endgenerate

	// the three single-bit sources sit at the top of the synchronised word
	assign thermal_s  = sync_in[SYNC_WIDTH-3];
	assign bat_oc_s   = sync_in[SYNC_WIDTH-2];
	assign reg_fail_s = sync_in[SYNC_WIDTH-1];

	// status follows the live fault state; software writes never touch it
	// flags are live levels rather than sticky bits, so no clear path is needed,
	// at the cost that a fault shorter than the filter may never be seen
	always_comb begin
		rail_d    = fault_now;
		summary_d = |fault_now;
		flags_d   = 3'h0;
		flags_d[BIT_THERMAL] = thermal_s;
		flags_d[BIT_SUMMARY] = summary_d | bat_oc_s;
		flags_d[BIT_REGFAIL] = reg_fail_s;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rail_q    <= '0;
			summary_q <= 1'b0;
			flags_q   <= FLAGS_RESET[2:0];
		end else begin
			rail_q    <= rail_d;
			summary_q <= summary_d;
			flags_q   <= flags_d;
		end
	end

	// write decode: only the mask address takes data; rail, flag and unmapped
	// addresses drop the write, so a stray write can never fake a fault
	always_comb begin
		mask_wr = REG_WR && (REG_ADDR == ADDR_L1_MASK);
	end

	// mask register is the only writable state; reserved bits 7:3 are dropped
	always_comb begin
		mask_d = mask_q;
		if (mask_wr) begin
			mask_d = REG_WDATA[2:0];
		end
	end

	// level-1 fault and the host pin follow the flags one cycle later, so a mask
	// write takes effect on the pin on the edge after the write is taken
	always_comb begin
		pend  = flags_q & ~mask_q;
		l1_d  = pend[BIT_SUMMARY];
		irq_d = |pend;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mask_q <= MASK_RESET;
			l1_q   <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			mask_q <= mask_d;
			l1_q   <= l1_d;
			irq_q  <= irq_d;
		end
	end

	// rail register images; reserved upper bits are tied low instead of stored,
	// so there is no flop that a write could ever reach
	always_comb begin
		rail_img_a = 8'h00;
		rail_img_d = 8'h00;
		rail_img_a[RAIL_A_BITS-1:0] = rail_q[RAIL_A_BASE +: RAIL_A_BITS];
		rail_img_b = rail_q[RAIL_B_BASE +: 8];
		rail_img_c = rail_q[RAIL_C_BASE +: 8];
		rail_img_d[RAIL_D_BITS-1:0] = rail_q[RAIL_D_BASE +: RAIL_D_BITS];
	end

	// extended region decode; a rail register answers only from inside it
	always_comb begin
		in_ext_region = REG_ADDR >= EXT_REGION_LO && REG_ADDR <= EXT_REGION_HI;
	end

	// read decode; reserved bits and unmapped addresses read as zero
	always_comb begin
		rd_mux = 8'h00;
		case (REG_ADDR)
			ADDR_RAIL_A: begin
				rd_mux = in_ext_region ? rail_img_a : 8'h00;
			end
			ADDR_RAIL_B: begin
				rd_mux = in_ext_region ? rail_img_b : 8'h00;
			end
			ADDR_RAIL_C: begin
				rd_mux = in_ext_region ? rail_img_c : 8'h00;
			end
			ADDR_RAIL_D: begin
				rd_mux = in_ext_region ? rail_img_d : 8'h00;
			end
			ADDR_L1_FLAGS: begin
				rd_mux[2:0] = flags_q;
			end
			ADDR_L1_MASK: begin
				rd_mux[2:0] = mask_q;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// a read strobe loads the holding register; without one the last answer stays
	always_comb begin
		rdata_d = rdata_q;
		if (REG_RD) begin
			rdata_d = rd_mux;
		end
	end

	// read data is held until the next read so the controller may sample late;
	// the price is one cycle of read latency on every access
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA              = rdata_q;
	assign SUPPLY_FAULT_SIGNAL    = rail_q;
	assign FAULT_SUMMARY_SOURCE   = summary_q;
	assign REGULATOR_FAULT_LEVEL1 = l1_q;
	assign HOST_INTERRUPT_PIN     = irq_q;
endmodule

// ---- verif/regulator_fault_aggregator_tb.sv ----
// self-checking bench for the regulator fault aggregator
`timescale 1ns/1ps
module regulator_fault_aggregator_tb;
	import rfa_pkg::*;
	logic                   CLK = 1'h0;
	logic                   SYS_RST = 1'h1;
	logic [3:0][26:0]       det = '0;
	logic                   THERMAL_WARN_DET = 1'h0;
	logic                   BAT_OVERCURR_DET = 1'h0;
	logic                   REGULATOR_FAIL_DET = 1'h0;
	logic [8:0]             REG_ADDR;
	logic                   REG_WR;
	logic                   REG_RD;
	logic [7:0]             REG_WDATA;
	logic [7:0]             REG_RDATA;
	logic [26:0]            SUPPLY_FAULT_SIGNAL;
	logic                   FAULT_SUMMARY_SOURCE;
	logic                   REGULATOR_FAULT_LEVEL1;
	logic                   HOST_INTERRUPT_PIN;
	logic [7:0]             f;
	logic [31:0]            r;
	logic [26:0]            e;
	int                     sup[8] = '{0, 6, 7, 14, 15, 22, 23, 26};
	int                     n_mismatch = 0;
	int                     check_count = 0;
	int                     cyc = 0;
	rfa_top u_dut (.UNDER_VOLT_DET(det[0]), .OVER_VOLT_DET(det[1]), .OVER_CURR_DET(det[2]),
		.SHORT_CIRC_DET(det[3]), .*);
	rfa_sysctl u_sysctl (.*);
	always #12.5 CLK = ~CLK;
	// hang guard, far above the few hundred cycles the tests need
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// margin over the six-cycle filter and pin latency
	task automatic settle;
		repeat (8) @(posedge CLK);
	endtask
	initial begin
		repeat (10) @(posedge CLK);
		SYS_RST <= 1'h0;
		settle;
		u_sysctl.svc(f, r);
		chk(f, 8'h00);
		chk(r, 32'h0);
		u_sysctl.rd(ADDR_L1_MASK, f);
		chk(f, 8'h03);
		u_sysctl.wr(ADDR_RAIL_A, 8'hFF);
		u_sysctl.wr(ADDR_RAIL_D, 8'hFF);
		u_sysctl.svc(f, r);
		chk(r, 32'h0);
		$display("reset and write test done");
		// one supply per register edge, each detector kind twice
		foreach (sup[i]) begin
			e = 27'h1 << sup[i];
			det[i % 4] <= e;
			settle;
			chk(SUPPLY_FAULT_SIGNAL, e);
			chk(FAULT_SUMMARY_SOURCE, 1'h1);
			chk(REGULATOR_FAULT_LEVEL1, 1'h0);
			chk(HOST_INTERRUPT_PIN, 1'h0);
			u_sysctl.svc(f, r);
			chk(f, 8'h02);
			chk(r, {4'h0, e[26:23], e[22:15], e[14:7], 1'h0, e[6:0]});
			det[i % 4] <= '0;
			settle;
		end
		$display("supply test done");
		// reserved mask bits set on purpose: only bits 2:0 may land
		u_sysctl.wr(ADDR_L1_MASK, 8'hFD);
		u_sysctl.rd(ADDR_L1_MASK, f);
		chk(f, 8'h05);
		det[2] <= 27'h1 << 9;
		settle;
		chk(REGULATOR_FAULT_LEVEL1, 1'h1);
		chk(HOST_INTERRUPT_PIN, 1'h1);
		u_sysctl.svc(f, r);
		chk(r, 32'h0000_0400);
		u_sysctl.wr(ADDR_L1_MASK, 8'h07);
		repeat (3) @(posedge CLK);
		chk(HOST_INTERRUPT_PIN, 1'h0);
		THERMAL_WARN_DET <= 1'h1;
		BAT_OVERCURR_DET <= 1'h1;
		REGULATOR_FAIL_DET <= 1'h1;
		u_sysctl.wr(ADDR_L1_MASK, 8'h06);
		settle;
		u_sysctl.rd(ADDR_L1_FLAGS, f);
		chk(f, 8'h07);
		chk(HOST_INTERRUPT_PIN, 1'h1);
		chk(REGULATOR_FAULT_LEVEL1, 1'h0);
		$display("interrupt test done");
		close_out;
	end
endmodule

// ---- verif/rfa_props.sv ----
// port-level assertions for the regulator fault aggregator
`timescale 1ns/1ps
module rfa_props
	import rfa_pkg::*;
(
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic [26:0] UNDER_VOLT_DET,
	input wire logic [26:0] OVER_VOLT_DET,
	input wire logic [26:0] OVER_CURR_DET,
	input wire logic [26:0] SHORT_CIRC_DET,
	input wire logic [8:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_WDATA,
	input wire logic [7:0]  REG_RDATA,
	input wire logic [26:0] SUPPLY_FAULT_SIGNAL,
	input wire logic        FAULT_SUMMARY_SOURCE,
	input wire logic        REGULATOR_FAULT_LEVEL1,
	input wire logic        HOST_INTERRUPT_PIN
);
	logic [2:0]  m_q;
	logic [2:0]  m_d;
	logic [26:0] det;
	assign det = UNDER_VOLT_DET | OVER_VOLT_DET | OVER_CURR_DET | SHORT_CIRC_DET;
	// mirror of the mask so pin checks need no look inside
	always_comb m_d = (REG_WR && REG_ADDR == ADDR_L1_MASK) ? REG_WDATA[2:0] : m_q;
	always_ff @(posedge CLK) m_q <= SYS_RST ? MASK_RESET : m_d;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence rd_at(logic [8:0] a);
		REG_RD && REG_ADDR == a;
	endsequence
	// seven steady cycles cover the filter latency with two spare
	a_rail_tracks: assert property ($stable(det)[*7] |-> SUPPLY_FAULT_SIGNAL == det)
		else $error("rail bits off");
	a_summary_or: assert property (FAULT_SUMMARY_SOURCE == |SUPPLY_FAULT_SIGNAL)
		else $error("summary off");
	a_level_set: assert property ($past(FAULT_SUMMARY_SOURCE && !m_q[1]) |-> REGULATOR_FAULT_LEVEL1)
		else $error("level1 missing");
	a_level_mask: assert property (REGULATOR_FAULT_LEVEL1 |-> !$past(m_q[1]))
		else $error("level1 masked");
	a_host_follow: assert property (REGULATOR_FAULT_LEVEL1 |-> HOST_INTERRUPT_PIN)
		else $error("host pin low");
	a_rail_a_read: assert property (rd_at(ADDR_RAIL_A) |=> REG_RDATA == {1'h0, $past(SUPPLY_FAULT_SIGNAL[6:0])})
		else $error("rail a read");
	a_rail_d_read: assert property (rd_at(ADDR_RAIL_D) |=> REG_RDATA == {4'h0, $past(SUPPLY_FAULT_SIGNAL[26:23])})
		else $error("rail d read");
	a_mask_read: assert property (rd_at(ADDR_L1_MASK) |=> REG_RDATA == {5'h00, $past(m_q)})
		else $error("mask read");
endmodule
bind rfa_top rfa_props u_props (.*);

// ---- verif/rfa_sc.sv ----
// system controller model driving the register strobe port
`timescale 1ns/1ps
module rfa_sysctl
	import rfa_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic [7:0] REG_RDATA,
	output logic      [8:0] REG_ADDR = 9'h000,
	output logic            REG_WR = 1'h0,
	output logic            REG_RD = 1'h0,
	output logic      [7:0] REG_WDATA = 8'h00
);
	// one-cycle strobe; address and data are scrambled once released
	task automatic acc(input logic [8:0] a, input logic w, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= w;
		REG_RD <= !w;
		@(posedge CLK);
		REG_ADDR <= ~a;
		REG_WDATA <= ~d;
		REG_WR <= 1'h0;
		REG_RD <= 1'h0;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		acc(a, 1'h1, d);
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		acc(a, 1'h0, 8'h00);
		@(posedge CLK);
		d = REG_RDATA;
	endtask
	// flags first, then the four rail registers to find the supply
	task automatic svc(output logic [7:0] f, output logic [31:0] r);
		logic [7:0] v;
		rd(ADDR_L1_FLAGS, f);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_RAIL_A + 9'(i), v);
			r[8*i +: 8] = v;
		end
	endtask
endmodule
